// [rtl/channel_queue_buffer.sv]
// What this block does
// [R1] One independent queue per decoupled channel: two for uncached TileLink, five otherwise.
// [R2] Every channel queue holds exactly its configured number of entries.
// [R3] Bypass option forwards input valid so an entry can leave the cycle it arrives.
// [R4] Ready pass-through couples output ready to input ready for full-rate single entries.
// [R5] A plain integer setting is the depth, with both coupling options off.
// [R6] Standard preset: two entries, no bypass, no ready pass-through.
// [R7] Empty preset: zero entries, no storage on that channel.
// [R8] Bypass preset: one entry, bypass on, ready pass-through off.
// [R9] Pipelined preset: one entry, ready pass-through on, bypass off.
// [R10] TileLink with no setting applies the standard preset to every channel.
// [R11] A single setting applies identically to all channels.
// [R12] Two TileLink settings: first for A, C, E; second for B, D.
// [R13] Five TileLink settings govern channels A, B, C, D, E in order.
// [R14] AXI with no setting applies the standard preset to all five channels.
// [R15] Two AXI settings: first for read-address, write-address, write-data; second for responses.
// [R16] Five AXI settings in order write-address, write-data, write-response, read-address, read-data.
// [R17] Handshakes kept, payloads unchanged and in order, no beat dropped or duplicated.
//
// Purpose: Per-channel queues on a TileLink or AXI link, with an APB control port
// Assumes: Single clock pclk at 125 MHz; link logic on the same clock
// Notes:   Channel index 0..4 is A..E for TileLink and aw, w, b, ar, r for AXI
`timescale 1ns/100ps
`include "channel_queue_defs.svh"

module channel_queue_fifo #(
    parameter int WIDTH  = 64,
    parameter int DEPTH  = `CQ_MAX_DEPTH,
    parameter bit BYPASS = 1'b0,
    parameter bit PIPE   = 1'b0
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    // Occupancy
    output logic      [3:0]       level
);
    localparam int DS = (DEPTH > 0) ? DEPTH : 1;
    localparam int PW = (DS > 1) ? $clog2(DS) : 1;
    localparam int CW = $clog2(DS + 2);

    typedef struct packed {
        logic [DS-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]            rd;
        logic [PW-1:0]            wr;
        logic [CW-1:0]            count;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;

    if (DEPTH < 0 || DEPTH > 15) begin : g_bad_depth
        $error("channel_queue_fifo: DEPTH out of range");
    end

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DS - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    logic empty;
    logic full;
    logic deq;
    logic enq;
    logic do_enq;
    logic do_deq;

    always_comb begin
        next_st   = st;
        empty     = (st.count == '0);
        full      = (st.count == CW'(DS));
        if (DEPTH == 0) begin
            // No storage: the channel is a plain wire pair
            out_valid = in_valid; // R7
            in_ready  = out_ready;
            out_data  = in_data;
        end else begin
            out_valid = !empty || (BYPASS && in_valid); // R3
            in_ready  = !full || (PIPE && out_ready); // R4
            out_data  = (BYPASS && empty) ? in_data : st.mem[st.rd];
        end
        deq    = out_valid && out_ready;
        enq    = in_valid && in_ready;
        // A bypassed beat leaves at once and is never written
        do_enq = (DEPTH > 0) && enq && !(BYPASS && empty && deq); // R17
        do_deq = (DEPTH > 0) && deq && !(BYPASS && empty);
        if (do_enq) begin
            next_st.mem[st.wr] = in_data; // R2
            next_st.wr         = ptr_inc(st.wr);
        end
        if (do_deq) begin
            next_st.rd = ptr_inc(st.rd);
        end
        if (do_enq && !do_deq) begin
            next_st.count = CW'(st.count + 1'b1);
        end else if (do_deq && !do_enq) begin
            next_st.count = CW'(st.count - 1'b1);
        end
        level = 4'(st.count);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

module channel_queue_buffer #(
    parameter channel_queue_pkg::protocol_t PROTOCOL = channel_queue_pkg::tl_uncached,
    parameter int                           DATA_W   = 64,
    parameter int                           NUM_SET  = 0,
    // Settings 0..4, depth nibble i at [4i+3:4i]; a plain integer leaves both flags 0
    parameter logic [19:0]                  SET_DEPTH  = 20'h22222,
    parameter logic [4:0]                   SET_BYPASS = 5'h00,
    parameter logic [4:0]                   SET_PIPE   = 5'h00
) (
    // Clock and reset
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    // APB slave
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [11:0]                     paddr,
    input  wire logic [31:0]                     pwdata,
    input  wire logic [3:0]                      pstrb,
    output logic                                 pready,
    output logic      [31:0]                     prdata,
    output logic                                 pslverr,
    // Channel inputs, index 0..4
    input  wire logic [`CQ_CHANNELS-1:0]         in_valid,
    output logic      [`CQ_CHANNELS-1:0]         in_ready,
    input  wire logic [`CQ_CHANNELS*DATA_W-1:0]  in_data,
    // Channel outputs, index 0..4
    output logic      [`CQ_CHANNELS-1:0]         out_valid,
    input  wire logic [`CQ_CHANNELS-1:0]         out_ready,
    output logic      [`CQ_CHANNELS*DATA_W-1:0]  out_data
);
    localparam int NCH = `CQ_CHANNELS;

    if (!(NUM_SET == 0 || NUM_SET == 1 || NUM_SET == 2 || NUM_SET == 5)) begin : g_bad_num
        $error("channel_queue_buffer: NUM_SET must be 0, 1, 2 or 5");
    end
    if (DATA_W < 1) begin : g_bad_width
        $error("channel_queue_buffer: DATA_W must be positive");
    end

    // Which supplied setting governs channel ch
    function automatic int set_index(input int ch);
        set_index = 0;
        if (NUM_SET == 1) begin
            set_index = 0; // R11
        end else if (NUM_SET == 2) begin
            if (PROTOCOL == channel_queue_pkg::axi_link) begin
                // aw, w, ar take the first; b, r the second
                set_index = (ch == 2 || ch == 4) ? 1 : 0; // R15
            end else begin
                // A, C, E take the first; B, D the second
                set_index = (ch == 1 || ch == 3) ? 1 : 0; // R12
            end
        end else if (NUM_SET == 5) begin
            set_index = ch; // R13 R16
        end
    endfunction

    function automatic channel_queue_pkg::queue_setting_t setting_of(input int ch);
        channel_queue_pkg::queue_setting_t s;
        int                                i;
        i = set_index(ch);
        if (NUM_SET == 0) begin
            s.depth  = `CQ_STD_DEPTH; // R6 R10 R14
            s.bypass = `CQ_STD_BYPASS;
            s.pipe   = `CQ_STD_PIPE;
        end else begin
            s.depth  = SET_DEPTH[4*i +: 4]; // R5
            s.bypass = SET_BYPASS[i];
            s.pipe   = SET_PIPE[i];
        end
        setting_of = s;
    endfunction

    // Uncached TileLink carries only A and D
    function automatic logic chan_active(input int ch);
        if (PROTOCOL == channel_queue_pkg::tl_uncached) begin
            chan_active = (ch == 0 || ch == 3); // R1
        end else begin
            chan_active = 1'b1; // R1
        end
    endfunction

    function automatic logic [3:0] level_nib(input logic [3:0] v);
        level_nib = v;
    endfunction

    typedef struct packed {
        logic [NCH-1:0] hold;
        logic [31:0]    rdata;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;

    logic [NCH-1:0]      q_in_ready;
    logic [NCH-1:0]      q_out_valid;
    logic [NCH-1:0][3:0] q_level;
    logic [31:0]         setting_word;

    for (genvar c = 0; c < NCH; c++) begin : g_chan
        localparam channel_queue_pkg::queue_setting_t S = setting_of(c);
        if (int'(S.depth) > `CQ_MAX_DEPTH) begin : g_too_deep
            $error("channel_queue_buffer: channel depth above limit");
        end
        if (chan_active(c)) begin : g_q
            logic in_v;
            logic out_r;
            // A held channel offers nothing downstream, so its queue fills up; a zero-depth one stalls its input
            assign in_v  = in_valid[c];
            assign out_r = out_ready[c] && !st.hold[c];
            channel_queue_fifo #(
                .WIDTH  (DATA_W),
                .DEPTH  (int'(S.depth)),
                .BYPASS (S.bypass),
                .PIPE   (S.pipe)
            ) u_fifo (
                .pclk      (pclk),
                .presetn   (presetn),
                .in_valid  (in_v),
                .in_ready  (q_in_ready[c]),
                .in_data   (in_data[c*DATA_W +: DATA_W]),
                .out_valid (q_out_valid[c]),
                .out_ready (out_r),
                .out_data  (out_data[c*DATA_W +: DATA_W]),
                .level     (q_level[c])
            ); // R2 R17
        end else begin : g_idle
            assign q_in_ready[c]                 = 1'b0;
            assign q_out_valid[c]                = 1'b0;
            assign q_level[c]                    = 4'h0;
            assign out_data[c*DATA_W +: DATA_W]  = '0;
        end
        assign setting_word[4*c +: 4]                = chan_active(c) ? S.depth : 4'h0;
        assign setting_word[`CQ_SET_BYP_LSB + c]     = chan_active(c) && S.bypass;
        assign setting_word[`CQ_SET_PIPE_LSB + c]    = chan_active(c) && S.pipe;
    end
    assign setting_word[31:30] = 2'h0;

    assign in_ready  = q_in_ready;
    assign out_valid = q_out_valid & ~st.hold;

    // Register decode and access
    logic mapped;
    logic wr_en;
    logic [31:0] rd_mux;

    always_comb begin
        next_st = st;
        mapped  = (paddr == `CQ_OFF_CTRL) || (paddr == `CQ_OFF_LEVEL)
                  || (paddr == `CQ_OFF_SETTING);
        wr_en   = psel && penable && pwrite && mapped;
        rd_mux  = 32'h0000_0000;
        case (paddr)
            `CQ_OFF_CTRL: begin
                rd_mux[`CQ_CTRL_HOLD_LSB +: NCH] = st.hold;
            end
            `CQ_OFF_LEVEL: begin
                for (int c = 0; c < NCH; c++) begin
                    rd_mux[c*`CQ_LEVEL_NIB_W +: `CQ_LEVEL_NIB_W] = level_nib(q_level[c]);
                end
            end
            `CQ_OFF_SETTING: begin
                rd_mux = setting_word;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
        // Read data is caught in the setup cycle so the slave needs no wait state
        if (psel && !penable) begin
            next_st.rdata = rd_mux;
        end
        if (wr_en && paddr == `CQ_OFF_CTRL && pstrb[0]) begin
            next_st.hold = pwdata[`CQ_CTRL_HOLD_LSB +: NCH];
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = st.rdata;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.hold  <= `CQ_CTRL_RESET;
            st.rdata <= 32'h0000_0000;
        end else begin
            st <= next_st;
        end
    end

endmodule

// [rtl/channel_queue_defs.svh]
// Purpose: Offsets, field positions, presets and reset values of the channel queue buffer
// Assumes: Included by its bare name from the design files
// Notes:   Definitions only
`ifndef CHANNEL_QUEUE_DEFS_SVH
`define CHANNEL_QUEUE_DEFS_SVH

// Register byte offsets on the APB port
`define CQ_OFF_CTRL       12'h000
`define CQ_OFF_LEVEL      12'h004
`define CQ_OFF_SETTING    12'h008

// Field layout
`define CQ_CTRL_HOLD_LSB  0
`define CQ_LEVEL_NIB_W    4
`define CQ_SET_BYP_LSB    20
`define CQ_SET_PIPE_LSB   25
`define CQ_CTRL_RESET     5'h00

// Channel count and depth limit
`define CQ_CHANNELS       5
`define CQ_MAX_DEPTH      4

// Presets: depth, bypass, ready pass-through
`define CQ_STD_DEPTH      4'h2
`define CQ_STD_BYPASS     1'b0
`define CQ_STD_PIPE       1'b0
`define CQ_EMPTY_DEPTH    4'h0
`define CQ_EMPTY_BYPASS   1'b0
`define CQ_EMPTY_PIPE     1'b0
`define CQ_BYP_DEPTH      4'h1 // R8
`define CQ_BYP_BYPASS     1'b1
`define CQ_BYP_PIPE       1'b0
`define CQ_PIPED_DEPTH    4'h1 // R9
`define CQ_PIPED_BYPASS   1'b0
`define CQ_PIPED_PIPE     1'b1

`endif

// [rtl/channel_queue_pkg.sv]
// Purpose: Types shared by the channel queue buffer
// Assumes: Nothing is imported; users write channel_queue_pkg::name
// Notes:   Channel order is the order of the five-setting form
package channel_queue_pkg;

    // Link flavour served by one instance
    typedef enum logic [2:0] {
        tl_uncached = 3'h1,
        tl_coherent = 3'h2,
        axi_link    = 3'h4
    } protocol_t;

    // One channel setting: entries plus the two coupling options
    typedef struct packed {
        logic [3:0] depth;
        logic       bypass;
        logic       pipe;
    } queue_setting_t;

endpackage

// [testbench/channel_queue_buffer_asserts.sv]
// Purpose: Port-level checks of channel_queue_buffer
// Assumes: Channel checks run only where five settings govern five live channels
// Notes:   Occupancy and hold bits are rebuilt from port traffic
`timescale 1ns/100ps
`include "channel_queue_defs.svh"

module channel_queue_buffer_asserts #(
    parameter bit          FIVE       = 1'b1,
    parameter int          DATA_W     = 64,
    parameter logic [19:0] SET_DEPTH  = 20'h22222,
    parameter logic [4:0]  SET_BYPASS = 5'h00,
    parameter logic [4:0]  SET_PIPE   = 5'h00
) (
    // Clock and reset
    input wire logic                            pclk,
    input wire logic                            presetn,
    // APB
    input wire logic                            psel,
    input wire logic                            penable,
    input wire logic                            pwrite,
    input wire logic [11:0]                     paddr,
    input wire logic [31:0]                     pwdata,
    input wire logic [3:0]                      pstrb,
    input wire logic                            pready,
    input wire logic                            pslverr,
    // Channels
    input wire logic [`CQ_CHANNELS-1:0]         in_valid,
    input wire logic [`CQ_CHANNELS-1:0]         in_ready,
    input wire logic [`CQ_CHANNELS*DATA_W-1:0]  in_data,
    input wire logic [`CQ_CHANNELS-1:0]         out_valid,
    input wire logic [`CQ_CHANNELS-1:0]         out_ready,
    input wire logic [`CQ_CHANNELS*DATA_W-1:0]  out_data
);
    logic [4:0] hold;
    logic [3:0] cnt [5];
    logic [4:0] in_fire;
    logic [4:0] out_fire;

    assign in_fire  = in_valid & in_ready;
    assign out_fire = out_valid & out_ready;

    // Held channels are excused from showing valid, so the mirror must track writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold <= 5'h00;
            for (int i = 0; i < 5; i++)
                cnt[i] <= 4'h0;
        end else begin
            if (psel && penable && pready && pwrite && pstrb[0] && paddr == `CQ_OFF_CTRL)
                hold <= pwdata[4:0];
            for (int i = 0; i < 5; i++)
                cnt[i] <= cnt[i] + 4'(in_fire[i]) - 4'(out_fire[i]);
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_zero_wait: assert property (psel && !penable |=> pready)
        else $error("access phase not answered at once");
    chk_unmapped_err: assert property (psel && penable |->
        pslverr == !(paddr inside {`CQ_OFF_CTRL, `CQ_OFF_LEVEL, `CQ_OFF_SETTING}))
        else $error("error flag does not match address");

    for (genvar g = 0; g < (FIVE ? 5 : 0); g++) begin : g_ch
        localparam logic [3:0] D = SET_DEPTH[4*g+:4];
        localparam bit         B = SET_BYPASS[g];
        localparam bit         P = SET_PIPE[g];
        sequence s_arrive;
            (D != 0 && in_fire[g] && cnt[g] == 4'h0) ##0 !out_fire[g];
        endsequence
        chk_depth_cap: assert property (cnt[g] <= D)
            else $error("occupancy above depth");
        chk_ready_space: assert property (D != 0 |->
            in_ready[g] == (cnt[g] < D || P && out_fire[g]))
            else $error("input ready wrong for occupancy");
        chk_valid_cause: assert property (D != 0 |->
            out_valid[g] == (!hold[g] && (cnt[g] != 0 || B && in_valid[g])))
            else $error("output valid without cause");
        chk_wire_thru: assert property (D == 0 && !hold[g] |->
            in_ready[g] == out_ready[g] && out_valid[g] == in_valid[g])
            else $error("empty channel not a wire");
        chk_pass_data: assert property ((D == 0 || B && cnt[g] == 0) && out_valid[g] |->
            out_data[g*DATA_W+:DATA_W] == in_data[g*DATA_W+:DATA_W])
            else $error("passed data differs");
        chk_beat_holds: assert property (out_valid[g] && !out_ready[g] |=>
            hold[g] || out_valid[g] && $stable(out_data[g*DATA_W+:DATA_W]))
            else $error("waiting beat changed");
        chk_enq_shows: assert property (s_arrive |=> out_valid[g] || hold[g])
            else $error("stored beat not offered");
    end
endmodule

bind channel_queue_buffer channel_queue_buffer_asserts #(
    .FIVE(NUM_SET == 5 && PROTOCOL != channel_queue_pkg::tl_uncached),
    .DATA_W(DATA_W), .SET_DEPTH(SET_DEPTH), .SET_BYPASS(SET_BYPASS), .SET_PIPE(SET_PIPE)
) i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data)
);

// [testbench/channel_sink.sv]
// Purpose: Far-side consumer of the five channel outputs
// Assumes: Mode 0 takes every beat, 1 stalls, 2 takes every other cycle
// Notes:   Ready does not wait for valid, which the handshake allows
`timescale 1ns/100ps

module channel_sink (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control and handshake
    input  wire logic [1:0] mode,
    output logic      [4:0] out_ready
);
    logic phase;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            phase <= 1'b0;
        else
            phase <= !phase;
    end

    always_comb begin
        case (mode)
            2'h0: out_ready = 5'h1F;
            2'h1: out_ready = 5'h00;
            default: out_ready = {5{phase}};
        endcase
    end
endmodule

// [testbench/tb_channel_queue_buffer.sv]
// Purpose: Self-checking bench of channel_queue_buffer
// Assumes: Coherent link, five settings: std, empty, bypass, pipelined, depth 4
//          A second, AXI instance with two settings only shows its setting decode
// Notes:   Beats are scored against per-channel expected queues
`timescale 1ns/100ps
`include "channel_queue_defs.svh"

module tb_channel_queue_buffer;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] d;
        logic        e;
    } row_t;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [31:0] prdata_axi;
    logic [4:0]  in_valid;
    logic [4:0]  in_ready;
    logic [39:0] in_data;
    logic [4:0]  out_valid;
    logic [4:0]  out_ready;
    logic [39:0] out_data;
    logic [4:0]  src_on;
    logic [1:0]  mode;
    logic [7:0]  exp_q [5][$];
    row_t        rows [4];
    int          mismatches;
    int          checks_done;

    channel_queue_buffer #(
        .PROTOCOL  (channel_queue_pkg::tl_coherent),
        .DATA_W    (8),
        .NUM_SET   (5),
        .SET_DEPTH ({4'h4, `CQ_PIPED_DEPTH, `CQ_BYP_DEPTH, `CQ_EMPTY_DEPTH, `CQ_STD_DEPTH}),
        .SET_BYPASS({1'b0, `CQ_PIPED_BYPASS, `CQ_BYP_BYPASS, `CQ_EMPTY_BYPASS, `CQ_STD_BYPASS}),
        .SET_PIPE  ({1'b0, `CQ_PIPED_PIPE, `CQ_BYP_PIPE, `CQ_EMPTY_PIPE, `CQ_STD_PIPE})
    ) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data)
    );

    // Shares the APB bus; only its read data is looked at
    channel_queue_buffer #(
        .PROTOCOL  (channel_queue_pkg::axi_link),
        .DATA_W    (8),
        .NUM_SET   (2),
        .SET_DEPTH (20'h00032),
        .SET_BYPASS(5'h01),
        .SET_PIPE  (5'h02)
    ) i_dut_axi (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(), .prdata(prdata_axi),
        .pslverr(), .in_valid(5'h00), .in_ready(), .in_data(40'h0),
        .out_valid(), .out_ready(5'h00), .out_data()
    );

    channel_sink i_sink (.pclk(pclk), .presetn(presetn), .mode(mode), .out_ready(out_ready));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task conclude();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task bail(input string what);
        mismatches++;
        $display("[FAIL] %0t %s", $time, what);
        conclude();
    endtask

    task cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // One idle cycle after each transfer keeps psel from being driven twice in a step
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
             output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= {4{wr}};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 50)
                bail("no pready");
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask

    task rd_chk(input logic [11:0] a, input logic [31:0] d, input logic e);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, rd, err);
        cmp(rd, d, "read data");
        cmp({31'h0, err}, {31'h0, e}, "error flag");
    endtask

    task until_zero(input logic sel, input logic [4:0] m);
        int n;
        n = 0;
        while (((sel ? out_valid : in_ready) & m) !== 5'h00) begin
            n++;
            if (n > 200)
                bail("wait ran out");
            @(posedge pclk);
        end
    endtask

    // Idle data changes every cycle so a stale beat can never match by chance
    always @(posedge pclk) begin
        if (!presetn) begin
            for (int i = 0; i < 5; i++)
                exp_q[i].delete();
            in_valid <= 5'h00;
            in_data <= 40'h0;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (in_valid[i] && in_ready[i])
                    exp_q[i].push_back(in_data[i*8+:8]);
                if (out_valid[i] && out_ready[i])
                    cmp(out_data[i*8+:8], exp_q[i].size() ? exp_q[i].pop_front() : 8'hXX, "beat");
                if (!(in_valid[i] && !in_ready[i]))
                    in_data[i*8+:8] <= in_data[i*8+:8] + 8'h35;
            end
            in_valid <= src_on | (in_valid & ~in_ready);
        end
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        src_on = 5'h00;
        mode = 2'h1;
        mismatches = 0;
        checks_done = 0;
        rows[0] = '{`CQ_OFF_CTRL, 32'h0, 1'b0};
        rows[1] = '{`CQ_OFF_LEVEL, 32'h0, 1'b0};
        rows[2] = '{`CQ_OFF_SETTING, 32'h10441102, 1'b0};
        rows[3] = '{12'h00C, 32'h0, 1'b1};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++)
            rd_chk(rows[i].a, rows[i].d, rows[i].e);
        rd_chk(`CQ_OFF_SETTING, 32'h10441102, 1'b0);
        cmp(prdata_axi, 32'h28B32322, "axi setting");
        src_on <= 5'h1F;
        @(posedge pclk);
        until_zero(1'b0, 5'h1F);
        src_on <= 5'h00;
        rd_chk(`CQ_OFF_LEVEL, 32'h00041102, 1'b0);
        wr(`CQ_OFF_CTRL, 32'h1);
        rd_chk(`CQ_OFF_CTRL, 32'h1, 1'b0);
        mode <= 2'h0;
        @(posedge pclk);
        until_zero(1'b1, 5'h1E);
        rd_chk(`CQ_OFF_LEVEL, 32'h2, 1'b0);
        wr(`CQ_OFF_CTRL, 32'h0);
        until_zero(1'b1, 5'h1F);
        wr(`CQ_OFF_LEVEL, 32'hFFFFFFFF);
        rd_chk(`CQ_OFF_LEVEL, 32'h0, 1'b0);
        rd_chk(`CQ_OFF_CTRL, 32'h0, 1'b0);
        src_on <= 5'h1F;
        mode <= 2'h2;
        repeat (60) @(posedge pclk);
        mode <= 2'h0;
        repeat (30) @(posedge pclk);
        src_on <= 5'h00;
        @(posedge pclk);
        until_zero(1'b1, 5'h1F);
        for (int i = 0; i < 5; i++)
            cmp(32'(exp_q[i].size()), 32'h0, "beats left");
        wr(`CQ_OFF_CTRL, 32'h10);
        mode <= 2'h1;
        src_on <= 5'h1F;
        repeat (4) @(posedge pclk);
        src_on <= 5'h00;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++)
            rd_chk(rows[i].a, rows[i].d, rows[i].e);
        conclude();
    end
endmodule
